// [common/lmb_consts.vh]
// Constants shared by the local memory bus master and its helpers
`ifndef LMB_CONSTS_VH
`define LMB_CONSTS_VH

// Transfer size codes on the core side
`define SZ_BYTE        2'h0
`define SZ_HALF        2'h1
`define SZ_WORD        2'h2

// Lane enable patterns, index 0 is the most significant byte lane
`define LANES_NONE     4'h0
`define LANES_B0       4'h8
`define LANES_B1       4'h4
`define LANES_B2       4'h2
`define LANES_B3       4'h1
`define LANES_HALF_HI  4'hc
`define LANES_HALF_LO  4'h3
`define LANES_WORD     4'hf

// Byte address bits inside the word (big-endian, 30 and 31)
`define ADDR_LO_MSB    30
`define ADDR_LO_LSB    31

// Reset values of bus-facing registers
`define ADDR_RST       32'h00000000
`define DATA_RST       32'h00000000
`define LANES_RST      4'h0

`endif

// [src/fetch_port.v]
// Instruction side of the local memory bus: reads only
`timescale 1ns/1ps
`include "lmb_consts.vh"

module fetch_port (
   input  wire        clk,
   input  wire        rst,
   input  wire        i_go,
   input  wire [0:31] i_addr,
   output reg         i_slot_full_r,
   output reg         i_done_r,
   output reg  [0:31] i_instr_r,
   output reg  [0:31] instr_addr_r,
   output reg         instr_start_strobe_r,
   output reg         fetch_in_progress_r,
   input  wire [0:31] instr_data,
   input  wire        instr_port_ready
);

   reg  [0:31] pend_addr_r;
   wire        go_ok     = i_go & ~i_slot_full_r;
   wire        can_issue = ~fetch_in_progress_r | instr_port_ready;
   wire        issue     = can_issue & (i_slot_full_r | go_ok);
   wire [0:31] src_addr  = i_slot_full_r ? pend_addr_r : i_addr;

   // Fetch engine; a queued fetch leaves on the ready edge so the
   // fetch strobe stays high across back-to-back reads
   always @(posedge clk) begin
      if (rst) begin
         instr_addr_r         <= `ADDR_RST;
         instr_start_strobe_r <= 1'b0;
         fetch_in_progress_r  <= 1'b0;
         pend_addr_r          <= `ADDR_RST;
         i_slot_full_r        <= 1'b0;
         i_done_r             <= 1'b0;
         i_instr_r            <= `DATA_RST;
      end else begin
         i_done_r <= fetch_in_progress_r & instr_port_ready;
         if (fetch_in_progress_r & instr_port_ready) begin
            i_instr_r <= instr_data;
         end
         if (issue) begin
            instr_addr_r         <= src_addr;
            instr_start_strobe_r <= 1'b1;
            fetch_in_progress_r  <= 1'b1;
         end else begin
            instr_start_strobe_r <= 1'b0;
            if (instr_port_ready) begin
               fetch_in_progress_r <= 1'b0;
            end
         end
         if (issue) begin
            i_slot_full_r <= 1'b0;
         end else if (go_ok) begin
            i_slot_full_r <= 1'b1;
            pend_addr_r   <= i_addr;
         end
      end
   end

endmodule

// [src/lane_steer.v]
// Lane enable decode, store data steering and load data steering
`timescale 1ns/1ps
`include "lmb_consts.vh"

module lane_steer (
   input  wire [1:0]  size,
   input  wire [0:1]  addr_lo,
   input  wire [0:31] reg_data,
   input  wire [0:3]  rd_lanes,
   input  wire [0:31] rd_bus,
   output reg  [0:3]  lanes,
   output reg  [0:31] wr_bus,
   output reg  [0:31] rd_data
);

   // Misaligned halfword or word addresses are aligned down, so only
   // the eight legal lane patterns can ever leave this block
   function [0:3] lane_decode;
      input [1:0] sz;
      input [0:1] lo;
      begin
         case (sz)
            `SZ_BYTE: begin
               case (lo)
                  2'h0:    lane_decode = `LANES_B0;
                  2'h1:    lane_decode = `LANES_B1;
                  2'h2:    lane_decode = `LANES_B2;
                  default: lane_decode = `LANES_B3;
               endcase
            end
            `SZ_HALF: lane_decode = lo[0] ? `LANES_HALF_LO : `LANES_HALF_HI;
            `SZ_WORD: lane_decode = `LANES_WORD;
            default:  lane_decode = `LANES_NONE;
         endcase
      end
   endfunction

   // Replicate the right-justified value into every lane it may use
   always @* begin
      lanes = lane_decode(size, addr_lo);
      case (size)
         `SZ_BYTE: wr_bus = {4{reg_data[24:31]}};
         `SZ_HALF: wr_bus = {2{reg_data[16:31]}};
         default:  wr_bus = reg_data;
      endcase
   end

   // Pick the enabled lanes of the load bus and right-justify them
   always @* begin
      case (rd_lanes)
         `LANES_B0:      rd_data = {24'h000000, rd_bus[0:7]};
         `LANES_B1:      rd_data = {24'h000000, rd_bus[8:15]};
         `LANES_B2:      rd_data = {24'h000000, rd_bus[16:23]};
         `LANES_B3:      rd_data = {24'h000000, rd_bus[24:31]};
         `LANES_HALF_HI: rd_data = {16'h0000, rd_bus[0:15]};
         `LANES_HALF_LO: rd_data = {16'h0000, rd_bus[16:31]};
         default:        rd_data = rd_bus;
      endcase
   end

endmodule

// [src/lmb_master.v]
// Local memory bus master: data port and instruction port of the core
`timescale 1ns/1ps
`include "lmb_consts.vh"

// How it works
// - Every bus signal is active high; no low-true signal anywhere.
// - All transfers run on the core clock, sampled on rising edges.
// - Address is driven and valid with the start strobe, first cycle.
// - Four lane enables mark valid byte lanes, valid with the start strobe.
// - Only patterns 0000,0001,0010,0100,1000,0011,1100,1111 are produced.
// - Store data appears with the start strobe, held past sampled ready.
// - Only enabled lanes carry valid store data; slave writes nothing else.
// - Start strobe is high only in the first cycle of each transfer.
// - Load strobe rises in the first read cycle, falls after ready.
// - A read issued right after ready keeps the load strobe high.
// - Store strobe rises in the first write cycle, falls after ready.
// - A write issued right after ready keeps the store strobe high.
// - Ready ends a transfer; the next may start the following cycle.
// - The protocol lets block RAM finish an access in one cycle.
// - Instruction port only reads: address, start, fetch, data, ready.
// - Bits and bytes are big-endian; index 0 is the most significant.
module lmb_master (
   input  wire        clk,
   input  wire        rst,
   // Core data requests
   input  wire        d_go,
   input  wire        d_write,
   input  wire [1:0]  d_size,
   input  wire [0:31] d_addr,
   input  wire [0:31] d_wdata,
   output reg         d_slot_full_r,
   output reg         d_done_r,
   output reg  [0:31] d_rdata_r,
   output reg         d_misalign_r,
   // Core fetch requests
   input  wire        i_go,
   input  wire [0:31] i_addr,
   output wire        i_slot_full_r,
   output wire        i_done_r,
   output wire [0:31] i_instr_r,
   // Data port of the bus
   output reg  [0:31] data_addr_r,
   output reg  [0:3]  lane_en_r,
   output reg  [0:31] store_data_r,
   output reg         data_start_strobe_r,
   output reg         load_in_progress_r,
   output reg         store_in_progress_r,
   input  wire [0:31] load_data,
   input  wire        data_port_ready,
   // Instruction port of the bus
   output wire [0:31] instr_addr_r,
   output wire        instr_start_strobe_r,
   output wire        fetch_in_progress_r,
   input  wire [0:31] instr_data,
   input  wire        instr_port_ready
);

   // ************************************************************
   // Data port state
   // ************************************************************

   // One-hot states of the data port engine
   localparam [1:0] D_IDLE = 2'b01;
   localparam [1:0] D_BUSY = 2'b10;

   reg  [1:0]  d_state_r;
   reg  [1:0]  d_state_nxt;

   // Single holding slot: one request may wait while another is on
   // the bus, which is what makes back-to-back transfers possible
   reg         pend_write_r;
   reg  [1:0]  pend_size_r;
   reg  [0:31] pend_addr_r;
   reg  [0:31] pend_wdata_r;

   // Flags an address that the size cannot reach without alignment
   function misaligned;
      input [1:0] sz;
      input [0:1] lo;
      begin
         case (sz)
            `SZ_HALF: misaligned = lo[1];
            `SZ_WORD: misaligned = |lo;
            default:  misaligned = 1'b0;
         endcase
      end
   endfunction

   // ************************************************************
   // Request selection
   // ************************************************************

   // A request from the core is ignored while the slot is occupied
   wire        go_ok   = d_go & ~d_slot_full_r;
   wire        src_vld = d_slot_full_r | go_ok;

   // The held request is older, so it always leaves first
   wire        src_write = d_slot_full_r ? pend_write_r : d_write;
   wire [1:0]  src_size  = d_slot_full_r ? pend_size_r  : d_size;
   wire [0:31] src_addr  = d_slot_full_r ? pend_addr_r  : d_addr;
   wire [0:31] src_wdata = d_slot_full_r ? pend_wdata_r : d_wdata;

   // Ready is sampled on the rising edge and frees the bus at once
   wire        d_busy    = d_state_r[1];
   wire        d_finish  = d_busy & data_port_ready;
   wire        can_issue = d_state_r[0] | data_port_ready;
   wire        issue     = can_issue & src_vld;

   wire [0:3]  src_lanes;
   wire [0:31] src_wbus;
   wire [0:31] steered_rd;

   // ************************************************************
   // Lane steering
   // ************************************************************

   // Read steering uses the lanes still held from the transfer's start
   lane_steer u_steer (
      .size     (src_size),
      .addr_lo  (src_addr[`ADDR_LO_MSB:`ADDR_LO_LSB]),
      .reg_data (src_wdata),
      .rd_lanes (lane_en_r),
      .rd_bus   (load_data),
      .lanes    (src_lanes),
      .wr_bus   (src_wbus),
      .rd_data  (steered_rd)
   );

   // ************************************************************
   // Data port sequencing
   // ************************************************************

   // Next state: issue wins over going idle, so the bus never shows
   // an empty cycle between two transfers that are ready to go
   always @* begin
      d_state_nxt = d_state_r;
      case (d_state_r)
         D_IDLE: begin
            if (issue) begin
               d_state_nxt = D_BUSY;
            end
         end
         D_BUSY: begin
            if (data_port_ready & ~issue) begin
               d_state_nxt = D_IDLE;
            end
         end
         default: begin
            d_state_nxt = D_IDLE;
         end
      endcase
   end

   // Bus-facing registers of the data port
   always @(posedge clk) begin
      if (rst) begin
         d_state_r           <= D_IDLE;
         data_addr_r         <= `ADDR_RST;
         lane_en_r           <= `LANES_RST;
         store_data_r        <= `DATA_RST;
         data_start_strobe_r <= 1'b0;
         load_in_progress_r  <= 1'b0;
         store_in_progress_r <= 1'b0;
      end else begin
         d_state_r <= d_state_nxt;
         if (issue) begin
            data_addr_r         <= src_addr;
            lane_en_r           <= src_lanes;
            store_data_r        <= src_write ? src_wbus : `DATA_RST;
            data_start_strobe_r <= 1'b1;
            load_in_progress_r  <= ~src_write;
            store_in_progress_r <= src_write;
         end else if (d_finish) begin
            // Nothing queued: both strobes drop after ready
            lane_en_r           <= `LANES_NONE;
            data_start_strobe_r <= 1'b0;
            load_in_progress_r  <= 1'b0;
            store_in_progress_r <= 1'b0;
         end else begin
            // Multicycle access: address, lanes and data simply hold
            data_start_strobe_r <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Holding slot
   // ************************************************************

   // The slot fills only when the bus cannot take the request now
   always @(posedge clk) begin
      if (rst) begin
         d_slot_full_r <= 1'b0;
         pend_write_r  <= 1'b0;
         pend_size_r   <= `SZ_BYTE;
         pend_addr_r   <= `ADDR_RST;
         pend_wdata_r  <= `DATA_RST;
      end else if (issue) begin
         d_slot_full_r <= 1'b0;
      end else if (go_ok) begin
         d_slot_full_r <= 1'b1;
         pend_write_r  <= d_write;
         pend_size_r   <= d_size;
         pend_addr_r   <= d_addr;
         pend_wdata_r  <= d_wdata;
      end
   end

   // ************************************************************
   // Completion toward the core
   // ************************************************************

   // Load data is only trusted on the edge where ready is high; it is
   // captured then because the slave may change it a cycle later
   always @(posedge clk) begin
      if (rst) begin
         d_done_r     <= 1'b0;
         d_rdata_r    <= `DATA_RST;
         d_misalign_r <= 1'b0;
      end else begin
         d_done_r     <= d_finish;
         d_misalign_r <= issue & misaligned(src_size, src_addr[`ADDR_LO_MSB:`ADDR_LO_LSB]);
         if (d_finish & load_in_progress_r) begin
            d_rdata_r <= steered_rd;
         end
      end
   end

   // ************************************************************
   // Instruction port
   // ************************************************************

   // Independent engine; fetches never wait on the data port
   fetch_port u_fetch (
      .clk                  (clk),
      .rst                  (rst),
      .i_go                 (i_go),
      .i_addr               (i_addr),
      .i_slot_full_r        (i_slot_full_r),
      .i_done_r             (i_done_r),
      .i_instr_r            (i_instr_r),
      .instr_addr_r         (instr_addr_r),
      .instr_start_strobe_r (instr_start_strobe_r),
      .fetch_in_progress_r  (fetch_in_progress_r),
      .instr_data           (instr_data),
      .instr_port_ready     (instr_port_ready)
   );

endmodule

// [tb/block_ram_slave_model.sv]
// Block RAM slave model answering both ports of the master
`timescale 1ns/1ps
module block_ram_slave_model (
   input  wire         clk,
   input  wire  [3:0]  d_lat,
   input  wire  [3:0]  i_lat,
   input  wire  [0:31] data_addr_r,
   input  wire  [0:3]  lane_en_r,
   input  wire  [0:31] store_data_r,
   input  wire         data_start_strobe_r,
   input  wire         store_in_progress_r,
   output logic [0:31] load_data,
   output logic        data_port_ready,
   input  wire  [0:31] instr_addr_r,
   input  wire         instr_start_strobe_r,
   output logic [0:31] instr_data,
   output logic        instr_port_ready
);
   // ****************************************
   // Memory and transfer trackers
   // ****************************************
   logic [0:31] mem [0:63];
   logic [0:31] d_a, i_a, d_last, i_last;
   logic [0:3]  d_ln;
   logic [3:0]  d_age, i_age;
   logic        d_act = 1'b0;
   logic        i_act = 1'b0;
   logic        d_wr;
   // Address and lanes count only in the start cycle, so they are latched there
   wire  [0:31] d_cur = data_start_strobe_r ? data_addr_r : d_a;
   wire  [0:3]  ln_cur = data_start_strobe_r ? lane_en_r : d_ln;
   wire         wr_cur = data_start_strobe_r ? store_in_progress_r : d_wr;
   wire  [0:31] i_cur = instr_start_strobe_r ? instr_addr_r : i_a;
   initial begin
      for (int k = 0; k < 64; k++) mem[k] = 32'h0;
      d_last = 32'h0;
      i_last = 32'h0;
   end
   // Ready after the programmed wait; a wait of 0 answers in the start cycle
   always_comb begin
      data_port_ready = (data_start_strobe_r || d_act)
         && ((data_start_strobe_r ? 4'h0 : d_age) == d_lat);
      instr_port_ready = (instr_start_strobe_r || i_act)
         && ((instr_start_strobe_r ? 4'h0 : i_age) == i_lat);
      // Outside ready the read buses carry the inverse of the last delivered word, so stale data cannot pass
      load_data = data_port_ready ? mem[d_cur[24:29]] : ~d_last;
      instr_data = instr_port_ready ? mem[i_cur[24:29]] : ~i_last;
   end
   // Commit only enabled lanes, at the edge that ends the write
   always @(posedge clk) begin
      if (data_port_ready) begin
         d_act <= 1'b0;
         d_last <= load_data;
         for (int k = 0; k < 4; k++)
            if (wr_cur && ln_cur[k])
               mem[d_cur[24:29]][8*k +: 8] <= store_data_r[8*k +: 8];
      end else if (data_start_strobe_r) begin
         d_act <= 1'b1;
         d_age <= 4'h1;
         d_a <= data_addr_r;
         d_ln <= lane_en_r;
         d_wr <= store_in_progress_r;
      end else if (d_act) d_age <= d_age + 4'h1;
      if (instr_port_ready) begin
         i_act <= 1'b0;
         i_last <= instr_data;
      end else if (instr_start_strobe_r) begin
         i_act <= 1'b1;
         i_age <= 4'h1;
         i_a <= instr_addr_r;
      end else if (i_act) i_age <= i_age + 4'h1;
   end
endmodule

// [tb/lmb_master_monitor.sv]
// Concurrent checks on the bus side of the local memory bus master
`timescale 1ns/1ps
module lmb_master_monitor (
   input wire        clk,
   input wire        rst,
   input wire        d_done_r,
   input wire [0:3]  lane_en_r,
   input wire [0:31] store_data_r,
   input wire        data_start_strobe_r,
   input wire        load_in_progress_r,
   input wire        store_in_progress_r,
   input wire        data_port_ready,
   input wire        instr_start_strobe_r,
   input wire        fetch_in_progress_r,
   input wire        instr_port_ready
);
   // ****************************************
   // Protocol checks, all on the core clock
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   start_once_a: assert property (disable iff (rst)
      data_start_strobe_r && !data_port_ready |=> !data_start_strobe_r) else $error("start twice");
   op_kind_a: assert property (disable iff (rst)
      data_start_strobe_r |-> load_in_progress_r ^ store_in_progress_r) else $error("bad kind");
   load_hold_a: assert property (disable iff (rst)
      load_in_progress_r && !data_port_ready |=> load_in_progress_r) else $error("load dropped");
   load_end_a: assert property (disable iff (rst)
      load_in_progress_r && data_port_ready
      |=> load_in_progress_r == (data_start_strobe_r && !store_in_progress_r))
      else $error("load end wrong");
   store_hold_a: assert property (disable iff (rst)
      store_in_progress_r && !data_port_ready |=> store_in_progress_r) else $error("store dropped");
   store_end_a: assert property (disable iff (rst)
      store_in_progress_r && data_port_ready
      |=> store_in_progress_r == (data_start_strobe_r && !load_in_progress_r))
      else $error("store end wrong");
   lane_set_a: assert property (disable iff (rst)
      data_start_strobe_r |-> lane_en_r inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})
      else $error("bad lanes");
   lane_idle_a: assert property (disable iff (rst)
      !load_in_progress_r && !store_in_progress_r |-> lane_en_r == 4'h0) else $error("idle lanes");
   wdata_hold_a: assert property (disable iff (rst)
      store_in_progress_r && !data_port_ready |=> $stable(store_data_r)) else $error("data moved");
   reset_quiet_a: assert property (
      rst |=> !(data_start_strobe_r || load_in_progress_r || store_in_progress_r
      || instr_start_strobe_r || fetch_in_progress_r)) else $error("strobe in reset");
   fetch_hold_a: assert property (disable iff (rst)
      fetch_in_progress_r && !instr_port_ready |=> fetch_in_progress_r) else $error("fetch dropped");
   fetch_start_a: assert property (disable iff (rst)
      instr_start_strobe_r && !instr_port_ready |-> fetch_in_progress_r ##1 !instr_start_strobe_r)
      else $error("fetch start wrong");
   done_follow_a: assert property (disable iff (rst)
      (load_in_progress_r || store_in_progress_r) && data_port_ready |=> d_done_r)
      else $error("no done");
endmodule
bind lmb_master lmb_master_monitor mon (.clk(clk), .rst(rst), .d_done_r(d_done_r),
   .lane_en_r(lane_en_r), .store_data_r(store_data_r), .data_start_strobe_r(data_start_strobe_r),
   .load_in_progress_r(load_in_progress_r), .store_in_progress_r(store_in_progress_r),
   .data_port_ready(data_port_ready), .instr_start_strobe_r(instr_start_strobe_r),
   .fetch_in_progress_r(fetch_in_progress_r), .instr_port_ready(instr_port_ready));

// [tb/lmb_master_tb_top.sv]
// Self-checking bench for the local memory bus master
`timescale 1ns/1ps
`include "lmb_consts.vh"
module lmb_master_tb_top;
   // ****************************************
   // Stimulus, model and scenarios
   // ****************************************
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        d_go = 1'b0, d_write = 1'b0, i_go = 1'b0;
   logic [1:0]  d_size = 2'h0;
   logic [0:31] d_addr = 32'h0, d_wdata = 32'h0, i_addr = 32'h0, rd;
   logic [3:0]  d_lat = 4'h0, i_lat = 4'h0;
   wire  [0:31] d_rdata_r, i_instr_r, data_addr_r, store_data_r, load_data, instr_addr_r, instr_data;
   wire  [0:3]  lane_en_r;
   wire         d_done_r, i_done_r, data_start_strobe_r, load_in_progress_r, store_in_progress_r;
   wire         d_slot_full_r, d_misalign_r, i_slot_full_r;
   logic        mis_exp = 1'b0;
   wire         data_port_ready, instr_start_strobe_r, fetch_in_progress_r, instr_port_ready;
   int          errors = 0, tests_run = 0;
   always #4 clk = ~clk;
   lmb_master dut (.clk(clk), .rst(rst), .d_go(d_go), .d_write(d_write), .d_size(d_size),
      .d_addr(d_addr), .d_wdata(d_wdata), .d_slot_full_r(d_slot_full_r), .d_done_r(d_done_r),
      .d_rdata_r(d_rdata_r), .d_misalign_r(d_misalign_r), .i_go(i_go), .i_addr(i_addr),
      .i_slot_full_r(i_slot_full_r),
      .i_done_r(i_done_r), .i_instr_r(i_instr_r), .data_addr_r(data_addr_r), .lane_en_r(lane_en_r),
      .store_data_r(store_data_r), .data_start_strobe_r(data_start_strobe_r),
      .load_in_progress_r(load_in_progress_r), .store_in_progress_r(store_in_progress_r),
      .load_data(load_data), .data_port_ready(data_port_ready), .instr_addr_r(instr_addr_r),
      .instr_start_strobe_r(instr_start_strobe_r), .fetch_in_progress_r(fetch_in_progress_r),
      .instr_data(instr_data), .instr_port_ready(instr_port_ready));
   block_ram_slave_model slave (.clk(clk), .d_lat(d_lat), .i_lat(i_lat), .data_addr_r(data_addr_r),
      .lane_en_r(lane_en_r), .store_data_r(store_data_r), .data_start_strobe_r(data_start_strobe_r),
      .store_in_progress_r(store_in_progress_r), .load_data(load_data),
      .data_port_ready(data_port_ready), .instr_addr_r(instr_addr_r),
      .instr_start_strobe_r(instr_start_strobe_r), .instr_data(instr_data),
      .instr_port_ready(instr_port_ready));
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [0:31] seen, input logic [0:31] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One data access; start and lanes are judged in the cycle after the request
   task automatic data_op(input logic w, input logic [1:0] sz, input logic [0:31] a,
                          input logic [0:31] wd, input logic [0:3] ln);
      int n;
      @(posedge clk);
      {d_go, d_write, d_size, d_addr, d_wdata} <= {1'b1, w, sz, a, wd};
      @(posedge clk);
      d_go <= 1'b0;
      #1;
      check(data_start_strobe_r, 32'h1);
      check(lane_en_r, ln);
      check(data_addr_r, a);
      check(d_misalign_r, mis_exp);
      for (n = 0; n < 20 && d_done_r !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      if (n == 20) begin
         errors++;
         final_report();
      end
      rd = d_rdata_r;
   endtask
   // Lane patterns: stores merge into one word, loads pick the word, single lanes and a halfword
   task automatic t_steer;
      d_lat <= 4'h1;
      data_op(1'b1, `SZ_WORD, 32'h40, 32'h11223344, `LANES_WORD);
      data_op(1'b1, `SZ_BYTE, 32'h41, 32'h000000aa, `LANES_B1);
      data_op(1'b1, `SZ_HALF, 32'h42, 32'h0000bbcc, `LANES_HALF_LO);
      data_op(1'b0, `SZ_WORD, 32'h40, 32'h0, `LANES_WORD);
      check(rd, 32'h11aabbcc);
      data_op(1'b0, `SZ_BYTE, 32'h43, 32'h0, `LANES_B3);
      check(rd, 32'h000000cc);
      data_op(1'b0, `SZ_BYTE, 32'h42, 32'h0, `LANES_B2);
      check(rd, 32'h000000bb);
      data_op(1'b0, `SZ_BYTE, 32'h40, 32'h0, `LANES_B0);
      check(rd, 32'h00000011);
      data_op(1'b0, `SZ_HALF, 32'h40, 32'h0, `LANES_HALF_HI);
      check(rd, 32'h000011aa);
      // Misaligned word: lanes aligned down, address unchanged, flag raised
      mis_exp = 1'b1;
      data_op(1'b0, `SZ_WORD, 32'h42, 32'h0, `LANES_WORD);
      mis_exp = 1'b0;
      check(rd, 32'h11aabbcc);
   endtask
   // Two requests in adjacent cycles; the second rides the edge of the first ready
   task automatic t_b2b(input logic w, input logic [3:0] lat);
      int n, seen;
      d_lat <= lat;
      @(posedge clk);
      {d_go, d_write, d_size, d_addr, d_wdata} <= {1'b1, w, `SZ_WORD, 32'h80, 32'h5a5a0001};
      @(posedge clk);
      {d_addr, d_wdata} <= {32'h84, 32'h5a5a0002};
      seen = 0;
      for (n = 0; n < 30; n++) begin
         @(posedge clk);
         d_go <= 1'b0;
         #1;
         if (n == 0) check(d_slot_full_r, lat != 4'h0);
         if (d_done_r === 1'b1) seen++;
      end
      check(seen, 32'h2);
      if (!w) check(d_rdata_r, 32'h5a5a0002);
   endtask
   // Instruction fetch with a given wait
   task automatic t_fetch(input logic [3:0] lat);
      int n;
      i_lat <= lat;
      @(posedge clk);
      {i_go, i_addr} <= {1'b1, 32'h40};
      @(posedge clk);
      i_go <= 1'b0;
      #1;
      check({instr_start_strobe_r, fetch_in_progress_r, i_slot_full_r}, 32'h6);
      check(instr_addr_r, 32'h40);
      for (n = 0; n < 20 && i_done_r !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      if (n == 20) begin
         errors++;
         final_report();
      end
      check(i_instr_r, 32'h11aabbcc);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1;
      check({data_start_strobe_r, load_in_progress_r, store_in_progress_r, lane_en_r},
            32'h0);
      @(posedge clk);
      rst <= 1'b0;
      t_steer();
      t_b2b(1'b1, 4'h0);
      t_b2b(1'b0, 4'h3);
      t_b2b(1'b0, 4'h0);
      t_fetch(4'h0);
      t_fetch(4'h2);
      final_report();
   end
endmodule
